// ===== pdmc_defines.vh
/*
  pdmc_defines.vh: constants for the power-down mode controller.
  assumes inclusion by bare name from the controller sources.
*/
// What this block does
// (R1) two power-down modes, sleep and standby, entered only from program execution
// (R2) power-down instruction enters sleep if standby-select bit is 0, else standby
// (R3) cpu halted in power-down; registers and ram contents held
// (R4) standby: ports hold levels or float, chosen by port-float bit
// (R5) standby keeps certain peripheral registers instead of resetting them
// (R6) exit on interrupt, dma address error, power-on reset or manual reset
// (R7) sleep keeps clock and peripherals running; standby stops both
`ifndef PDMC_DEFINES_VH
`define PDMC_DEFINES_VH
`define PDMC_ST_RUN        3'h1
`define PDMC_ST_SLEEP      3'h2
`define PDMC_ST_STANDBY    3'h4
`define PDMC_SCR_SELECT_BIT 7
`define PDMC_SCR_FLOAT_BIT  6
`define PDMC_SCR_RESET      8'h00
`define PDMC_SCR_MASK       8'hC0
`define PDMC_EV_IRQ         0
`define PDMC_EV_DMA_ERR     1
`define PDMC_EV_MRST        2
`endif

// ===== pdmc_sync.v
/*
  pdmc_sync.v: two-flop synchroniser bank for the exit event pins.
  assumes inputs are asynchronous to ref_clk_i.
*/
`timescale 1ns/100ps
module pdmc_sync (
  // clock and reset
  input  wire       ref_clk_i,
  input  wire       reset_i,
  // raw and synchronised levels
  input  wire [2:0] async_i,
  output wire [2:0] sync_o
);
  reg [2:0] stage1;
  reg [2:0] stage2;
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      stage1 <= 3'h0;
      stage2 <= 3'h0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end
  assign sync_o = stage2;
endmodule // pdmc_sync

// ===== pdmc_ctrl.v
/*
  pdmc_ctrl.v: power-down mode controller top.
  holds the standby control register, the run/sleep/standby state machine
  and the registered lines that halt the core, stop the clock and the
  peripherals, keep peripheral registers and set the i/o port behaviour.
  assumes the cpu core raises sleep_insn_i for one cycle when it executes the
  power-down instruction, and that the core is in program execution only
  while exec_state_i is high; both come from logic on ref_clk_i.
  register writes come from the core on ref_clk_i as well.
  exit events arrive as async level pins, held until the exit shows.
  reset_i is the power-on reset and is already synchronous to ref_clk_i.
*/
`timescale 1ns/100ps
`include "pdmc_defines.vh"
module pdmc_ctrl (
  // clock and reset
  input  wire       ref_clk_i,
  input  wire       reset_i,
  // cpu side
  input  wire       sleep_insn_i,
  input  wire       exec_state_i,
  input  wire       standby_control_register_we_i,
  input  wire [7:0] standby_control_register_wdata_i,
  output reg  [7:0] standby_control_register_o,
  // exit event pins
  input  wire       irq_i,
  input  wire       dma_addr_err_i,
  input  wire       manual_reset_i,
  // controls to the rest of the chip
  output reg        cpu_halt_o,
  output reg        clk_stop_o,
  output reg        periph_stop_o,
  output reg        periph_reg_hold_o,
  output reg        port_float_o,
  output reg        port_hold_o,
  output reg        manual_reset_o,
  // mode flags
  output reg        sleep_mode_o,
  output reg        standby_mode_o
);

  // state codes, one-hot
  localparam [2:0] ST_RUN     = `PDMC_ST_RUN;
  localparam [2:0] ST_SLEEP   = `PDMC_ST_SLEEP;
  localparam [2:0] ST_STANDBY = `PDMC_ST_STANDBY;

  // state decodes, shared by the register write gate and the output logic
  function is_running;
    input [2:0] st;
    begin
      is_running = (st == ST_RUN);
    end
  endfunction

  function is_sleep;
    input [2:0] st;
    begin
      is_sleep = (st == ST_SLEEP);
    end
  endfunction

  function is_standby;
    input [2:0] st;
    begin
      is_standby = (st == ST_STANDBY);
    end
  endfunction

  // either power-down mode
  function is_power_down;
    input [2:0] st;
    begin
      is_power_down = (st == ST_SLEEP) || (st == ST_STANDBY);
    end
  endfunction

  // ports float only in standby and only when software asked for it
  function ports_float;
    input [2:0] st;
    input       float_bit;
    begin
      ports_float = (st == ST_STANDBY) && float_bit;
    end
  endfunction

  // synchronised exit events, one lane per pin
  wire [2:0] ev_pins;
  wire [2:0] ev_sync;
  wire       wake_ev;
  // state machine and register
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [7:0] standby_control_register;
  reg  [7:0] next_standby_control_register;
  wire       write_taken;
  wire       standby_select_bit;
  wire       next_port_float_bit;
  // next values of the registered outputs
  reg        next_cpu_halt;
  reg        next_clk_stop;
  reg        next_periph_stop;
  reg        next_periph_reg_hold;
  reg        next_port_float;
  reg        next_port_hold;
  reg        next_manual_reset;
  reg        next_sleep_mode;
  reg        next_standby_mode;

  // pins packed into lanes by name, so a lane move needs one edit
  assign ev_pins[`PDMC_EV_IRQ]     = irq_i;
  assign ev_pins[`PDMC_EV_DMA_ERR] = dma_addr_err_i;
  assign ev_pins[`PDMC_EV_MRST]    = manual_reset_i;

  // pins are async to ref_clk_i; two flops before any decode
  pdmc_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   (ev_pins),
    .sync_o    (ev_sync)
  );

  // any synchronised event ends a power-down mode
  assign wake_ev = ev_sync[`PDMC_EV_IRQ] | ev_sync[`PDMC_EV_DMA_ERR] | ev_sync[`PDMC_EV_MRST];

  // writes only while running; a halted core cannot issue one anyway
  assign write_taken = standby_control_register_we_i && is_running(state);
  // mode chosen from the register as it stood before this edge, so a write
  // in the same cycle as the instruction applies to the next entry
  assign standby_select_bit = standby_control_register[`PDMC_SCR_SELECT_BIT];
  // float taken from the next register value: port lines and register
  // copy then never disagree for a cycle
  assign next_port_float_bit = next_standby_control_register[`PDMC_SCR_FLOAT_BIT];

  always @* begin
    next_standby_control_register = standby_control_register;
    if (write_taken) begin
      next_standby_control_register = standby_control_register_wdata_i & `PDMC_SCR_MASK;
    end
  end

  // reset_i is power-on reset: everything back to defaults
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      standby_control_register <= `PDMC_SCR_RESET;
    end else begin
      standby_control_register <= next_standby_control_register;
    end
  end

  // no indication when an entry is refused; the core simply carries on
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (sleep_insn_i && exec_state_i) begin // [R1]
          next_state = standby_select_bit ? ST_STANDBY : ST_SLEEP; // [R2]
        end
      end
      ST_SLEEP: begin
        if (wake_ev) begin // [R6]
          next_state = ST_RUN;
        end
      end
      ST_STANDBY: begin
        if (wake_ev) begin // [R6]
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= ST_RUN; // [R6]
    end else begin
      state <= next_state;
    end
  end

  // outputs except manual reset follow next_state so they line up with the state itself
  // halt only; register and ram contents are untouched by this block
  always @* begin
    next_cpu_halt        = is_power_down(next_state); // [R3]
    next_clk_stop        = is_standby(next_state); // [R7]
    next_periph_stop     = is_standby(next_state); // [R7]
    next_periph_reg_hold = is_standby(next_state); // [R5]
    next_port_float      = ports_float(next_state, next_port_float_bit); // [R4]
    next_port_hold       = is_power_down(next_state) && !next_port_float; // [R4]
    // manual reset exits and resets the core, but keeps this register
    next_manual_reset    = ev_sync[`PDMC_EV_MRST]; // [R6]
    next_sleep_mode      = is_sleep(next_state);
    next_standby_mode    = is_standby(next_state);
  end

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      cpu_halt_o                 <= 1'b0;
      clk_stop_o                 <= 1'b0;
      periph_stop_o              <= 1'b0;
      periph_reg_hold_o          <= 1'b0;
      port_float_o               <= 1'b0;
      port_hold_o                <= 1'b0;
      manual_reset_o             <= 1'b0;
      sleep_mode_o               <= 1'b0;
      standby_mode_o             <= 1'b0;
      standby_control_register_o <= `PDMC_SCR_RESET;
    end else begin
      cpu_halt_o                 <= next_cpu_halt; // [R3]
      clk_stop_o                 <= next_clk_stop; // [R7]
      periph_stop_o              <= next_periph_stop; // [R7]
      periph_reg_hold_o          <= next_periph_reg_hold; // [R5]
      port_float_o               <= next_port_float; // [R4]
      port_hold_o                <= next_port_hold; // [R4]
      manual_reset_o             <= next_manual_reset; // [R6]
      sleep_mode_o               <= next_sleep_mode;
      standby_mode_o             <= next_standby_mode;
      standby_control_register_o <= next_standby_control_register;
    end
  end
endmodule // pdmc_ctrl

// ===== pdmc_chk.sv
/* pdmc_chk: port assertions for the power-down mode controller.
   assumes a by-name bind to every pdmc_ctrl instance. */
`timescale 1ns/100ps
module pdmc_chk (
  // clock, reset and cpu side
  input wire       ref_clk_i, reset_i, sleep_insn_i, exec_state_i,
  input wire [7:0] standby_control_register_o,
  // wake pins and mode controls
  input wire       irq_i, dma_addr_err_i, manual_reset_i, cpu_halt_o, clk_stop_o, periph_stop_o,
  input wire       periph_reg_hold_o, port_float_o, port_hold_o, sleep_mode_o, standby_mode_o, manual_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  wire go = !cpu_halt_o && sleep_insn_i && exec_state_i;
  wire ev = irq_i || dma_addr_err_i || manual_reset_i;
  a_entry_by_bit: assert property (go |=> standby_mode_o == $past(standby_control_register_o[7]))
    else $error("mode does not follow standby select");
  a_refuse_entry: assert property (!cpu_halt_o && !go |=> !cpu_halt_o) else $error("halt without entry");
  a_one_mode: assert property (cpu_halt_o |-> sleep_mode_o != standby_mode_o) else $error("mode flags");
  a_halt_in_mode: assert property (cpu_halt_o == (sleep_mode_o || standby_mode_o)) else $error("halt");
  a_stop_standby: assert property (clk_stop_o == standby_mode_o && periph_stop_o == standby_mode_o)
    else $error("stop");
  a_mrst_follow: assert property (manual_reset_o == $past(manual_reset_i, 3)) else $error("manual reset");
  a_regs_kept: assert property (periph_reg_hold_o == standby_mode_o) else $error("register hold");
  a_port_state: assert property (port_float_o == (standby_mode_o && standby_control_register_o[6])
    && port_hold_o == (cpu_halt_o && !port_float_o)) else $error("port control");
  a_wake_bound: assert property (cpu_halt_o && ev |-> ##[1:3] !cpu_halt_o) else $error("no wake");
  c_sleep: cover property (go ##1 sleep_mode_o);
  c_float: cover property (port_float_o);
  c_refused: cover property (!cpu_halt_o && sleep_insn_i && !exec_state_i);
  c_standby_wake: cover property (standby_mode_o ##1 !standby_mode_o);
endmodule // pdmc_chk
bind pdmc_ctrl pdmc_chk u_chk (.*);

// ===== pdmc_cpu.sv
/* pdmc_cpu: behavioural cpu core issuing the power-down instruction.
   assumes the bench calls pd while the controller is running. */
`timescale 1ns/100ps
module pdmc_cpu (
  input  wire       ref_clk_i,
  output reg        sleep_insn_o,
  output reg        exec_state_o,
  output reg        ctrl_we_o,
  output reg  [7:0] ctrl_wdata_o
);
  // idle: executing, no instruction, no write
  initial {sleep_insn_o, exec_state_o, ctrl_we_o, ctrl_wdata_o} = 11'h200;
  // write first, instruction next cycle: tightest legal spacing
  task pd(input [7:0] cr, input ex);
    begin
      @(negedge ref_clk_i) {ctrl_we_o, ctrl_wdata_o} = {1'b1, cr};
      @(negedge ref_clk_i) {ctrl_we_o, sleep_insn_o, exec_state_o} = {2'b01, ex};
      @(negedge ref_clk_i) {sleep_insn_o, exec_state_o} = 2'b01;
    end
  endtask
  // lone register write, one cycle
  task wr(input [7:0] cr);
    begin
      @(negedge ref_clk_i) {ctrl_we_o, ctrl_wdata_o} = {1'b1, cr};
      @(negedge ref_clk_i) ctrl_we_o = 1'b0;
    end
  endtask
endmodule // pdmc_cpu

// ===== test_power_down_mode_control.sv
/* test_power_down_mode_control: directed bench for pdmc_ctrl.
   assumes pdmc_cpu drives the cpu side; wake pins driven here. */
`timescale 1ns/100ps
module test_power_down_mode_control;
  reg        ref_clk_i = 0, reset_i = 1;
  reg  [2:0] ev = 3'h0;
  wire       ins, ex, we, mr;
  wire [7:0] wd, cr, st;
  integer    mismatches = 0, cmp_count = 0, cyc = 0;
  initial forever #10 ref_clk_i = ~ref_clk_i;
  pdmc_cpu cpu (.ref_clk_i(ref_clk_i), .sleep_insn_o(ins), .exec_state_o(ex), .ctrl_we_o(we), .ctrl_wdata_o(wd));
  pdmc_ctrl dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .sleep_insn_i(ins), .exec_state_i(ex),
    .standby_control_register_we_i(we), .standby_control_register_wdata_i(wd),
    .standby_control_register_o(cr), .irq_i(ev[0]),
    .dma_addr_err_i(ev[1]), .manual_reset_i(ev[2]), .sleep_mode_o(st[7]), .standby_mode_o(st[6]),
    .cpu_halt_o(st[5]), .clk_stop_o(st[4]), .periph_stop_o(st[3]), .periph_reg_hold_o(st[2]),
    .port_float_o(st[1]), .port_hold_o(st[0]), .manual_reset_o(mr));
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // sync pins need three edges; pin held until exit seen
  task wake(input [2:0] p);
    integer i;
    begin
      @(negedge ref_clk_i) ev = p;
      for (i = 0; i < 4 && st[5] !== 1'b0; i = i + 1) @(negedge ref_clk_i);
      chk("wakelat", 8'h03, i[7:0]);
      chk("woken", 8'h00, st);
      chk("mrst", {7'h00, p[2]}, {7'h00, mr});
      ev = 3'h0;
      repeat (3) @(negedge ref_clk_i);
    end
  endtask
  task sc_sleep; begin cpu.pd(8'h00, 1'b1); chk("sleep", 8'hA1, st); wake(3'h1); end endtask
  task sc_hold;
    begin
      cpu.pd(8'h80, 1'b1);
      chk("standby", 8'h7D, st);
      chk("reg", 8'h80, cr);
      cpu.wr(8'h40);
      chk("regkeep", 8'h80, cr);
      chk("modekeep", 8'h7D, st);
      wake(3'h2);
    end
  endtask
  task sc_float;
    begin
      cpu.pd(8'hFF, 1'b1);
      chk("float", 8'h7E, st);
      chk("mask", 8'hC0, cr);
      wake(3'h4);
    end
  endtask
  task sc_refuse; begin cpu.pd(8'h80, 1'b0); chk("refused", 8'h00, st); end endtask
  task sc_por;
    begin
      cpu.pd(8'h40, 1'b1);
      chk("sleepfl", 8'hA1, st);
      @(negedge ref_clk_i) reset_i = 1;
      @(negedge ref_clk_i) reset_i = 0;
      chk("por", 8'h00, st);
      chk("reg", 8'h00, cr);
    end
  endtask
  task tally_and_finish;
    begin
      $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc > 2000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(negedge ref_clk_i);
    reset_i = 0;
    sc_sleep;
    sc_hold;
    sc_float;
    sc_refuse;
    sc_por;
    tally_and_finish;
  end
endmodule // test_power_down_mode_control
